// [core/seq_pkg.sv]
/*
  constants for the eight-slot waveform sequencer: register indices,
  field positions, reset values and the pause time base.
  assumes a 10 MHz register clock and 32-bit apb data.
*/
package seq_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONTROL      = 6'h0C;  // start bit lives here
  localparam logic [5:0] IDX_SLOT_FIRST   = 6'h0F;  // first sequence slot
  localparam logic [5:0] IDX_SLOT_SIX     = 6'h14;  // sequence_slot_six
  localparam logic [5:0] IDX_SLOT_SEVEN   = 6'h15;  // sequence_slot_seven
  localparam logic [5:0] IDX_SLOT_LAST    = 6'h16;  // eighth sequence slot
  localparam logic [5:0] IDX_STATUS       = 6'h18;  // sequencer state readback
  localparam int         SLOT_COUNT       = 8;
  localparam logic [2:0] SLOT_PTR_LAST    = 3'h7;
  // slot field layout
  localparam int         SLOT_MODE_BIT    = 7;      // 1 = pause, 0 = effect
  localparam int         SLOT_VALUE_MSB   = 6;
  localparam logic [7:0] SLOT_RESET       = 8'h00;
  localparam logic [6:0] VALUE_END_MARKER = 7'h00;
  // control and status fields
  localparam int         CTRL_START_BIT   = 0;
  localparam int         STAT_PTR_LSB     = 0;      // bits 2:0 current slot
  localparam int         STAT_PAUSE_BIT   = 4;
  localparam int         STAT_PLAY_BIT    = 5;
  localparam int         STAT_BUSY_BIT    = 6;
  // pause time base
  localparam int         CLK_KHZ          = 10000;  // pclk rate
  localparam int         PAUSE_UNIT_MS    = 10;     // one step of a pause slot
  localparam int         PAUSE_UNIT_CYCLES = PAUSE_UNIT_MS * CLK_KHZ;
  // sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_FETCH,
    SEQ_PLAY,
    SEQ_PAUSE
  } seq_state_t;
endpackage : seq_pkg

// [core/pause_timer.sv]
/*
  pause timer: counts a loaded number of pause units, each unit a fixed
  number of pclk cycles, and pulses done when the last unit ends.
  assumes load is a one-cycle pulse with a non-zero count.
*/
`timescale 1ns/1ps
module pause_timer #(
  parameter int UNIT_CYCLES = seq_pkg::PAUSE_UNIT_CYCLES
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       load,
  input  wire logic       abort,
  input  wire logic [6:0] units,
  output logic            done
);
  import seq_pkg::*;

  logic [16:0] tick_count;   // cycles within the current unit
  logic [6:0]  units_left;   // units still to run
  logic        running;      // a pause is in progress
  wire         unit_end = running && (tick_count == 17'(UNIT_CYCLES - 1));

  // tick counter divides pclk down to the pause unit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_count <= '0;
      units_left <= '0;
      running    <= 1'b0;
      done       <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin                       // software stopped playback
        running <= 1'b0;
      end else if (load) begin               // fresh pause, count from zero
        tick_count <= '0;
        units_left <= units;
        running    <= 1'b1;
      end else if (unit_end) begin
        tick_count <= '0;
        units_left <= units_left - 7'h01;
        if (units_left == 7'h01) begin       // last unit ends the pause
          running <= 1'b0;
          done    <= 1'b1;
        end
      end else if (running) begin
        tick_count <= tick_count + 17'h00001;
      end
    end
  end
endmodule : pause_timer

// [core/waveform_sequencer_slots.sv]
/*
  eight-slot waveform sequencer with its apb register file: the slot
  registers, the start bit and a status word, plus the walk over slots.
  assumes an effect player on the same clock that takes effect_start
  with effect_index and answers with a one-cycle effect_done.
*/
// Local design decision: register access over APB.
// Summary of operation
// RQ1: mode one: value times 10 ms pause
// RQ2: mode zero: value is waveform identifier
// RQ3: identifier bits six to zero index library
// RQ4: start bit begins playback at first slot
// RQ5: finished slot advances to next slot
// RQ6: stop at zero or after eighth slot
// RQ7: zero value ends sequence, not played
// RQ8: mode and value read/write, reset zero
// RQ9: tick counter pause, no drive meanwhile
`timescale 1ns/1ps
module waveform_sequencer_slots #(
  parameter int PAUSE_CYCLES = seq_pkg::PAUSE_UNIT_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        effect_done,
  output logic             effect_start,
  output logic [6:0]       effect_index,
  output logic             drive_enable
);
  import seq_pkg::*;

  // block layout, from the bus inwards:
  //   address decode turns the byte address into a register index and
  //   picks out the slot, control and status words;
  //   the slot file holds eight bytes, each a mode bit over a 7-bit value;
  //   the walk steps a slot pointer through the file, one slot at a time;
  //   the handshake stage turns each effect slot into a start pulse for the
  //   effect player, and each pause slot into a load of the pause timer.
  // the player and this block share pclk, so effect_done needs no
  // synchroniser; a player on another clock would have to add one.

  // slots are kept as a plain array so the walk can index them directly
  logic [7:0]  slot [SLOT_COUNT];   // the eight sequence slots
  seq_state_t  state;               // sequencer state
  logic [2:0]  slot_ptr;            // slot being played
  logic        pause_done;          // end of a pause slot

  // decode helpers
  function automatic logic is_slot(input logic [5:0] idx);
    is_slot = (idx >= IDX_SLOT_FIRST) && (idx <= IDX_SLOT_LAST);
  endfunction : is_slot

  function automatic logic [2:0] slot_of(input logic [5:0] idx);
    slot_of = 3'(idx - IDX_SLOT_FIRST);
  endfunction : slot_of

  // apb address decode
  wire [5:0] reg_idx    = paddr[7:2];
  wire       aligned    = (paddr[1:0] == 2'b00);
  wire       hit_slot   = aligned && is_slot(reg_idx);
  wire       hit_ctrl   = aligned && (reg_idx == IDX_CONTROL);
  wire       hit_stat   = aligned && (reg_idx == IDX_STATUS);
  wire       mapped     = hit_slot || hit_ctrl || hit_stat;
  wire       setup      = psel && !penable;
  wire       commit     = psel && penable && pready;
  wire       wr_commit  = commit && pwrite && mapped;
  wire       wr_slot    = wr_commit && hit_slot;
  wire       wr_ctrl    = wr_commit && hit_ctrl;
  wire       busy       = (state != SEQ_IDLE);
  wire       start_req  = wr_ctrl && pwdata[CTRL_START_BIT] && !busy;
  wire       stop_req   = wr_ctrl && !pwdata[CTRL_START_BIT] && busy;

  // current slot fields
  wire [7:0] cur_slot   = slot[slot_ptr];
  wire       cur_pause  = cur_slot[SLOT_MODE_BIT];            // RQ1
  wire [6:0] cur_value  = cur_slot[SLOT_VALUE_MSB:0];         // RQ3
  wire       cur_end    = (cur_value == VALUE_END_MARKER);    // RQ7
  wire       at_last    = (slot_ptr == SLOT_PTR_LAST);
  wire       step_done  = ((state == SEQ_PLAY) && effect_done)
                          || ((state == SEQ_PAUSE) && pause_done);

  // read data selection
  // status packs the walk state for software that polls instead of waiting
  wire [31:0] stat_word = {25'h0, busy, (state == SEQ_PLAY),
                           (state == SEQ_PAUSE), 1'b0, slot_ptr};
  wire [31:0] read_word = hit_slot ? {24'h000000, slot[slot_of(reg_idx)]}
                        : hit_ctrl ? {31'h0, busy}
                        : hit_stat ? stat_word
                        : 32'h00000000;

  // apb answer: one access cycle, no wait states, error on unmapped
  // pready is raised from the setup cycle, so it is high in exactly the
  // first access cycle; a master that stretched setup would still be
  // answered one cycle after its last setup cycle.
  // read data is captured at setup, so a slot that the walk cannot change
  // reads back the value it held when the transfer began.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && !pwrite) ? read_word : 32'h00000000;
    end
  end

  // slot registers, full byte writable, cleared at reset
  // writes land only at the access edge with pready high, never at setup.
  // slots stay writable while the walk runs; a slot rewritten ahead of the
  // pointer is seen when it is fetched, one already played is not replayed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        slot[i] <= SLOT_RESET;                                 // RQ8
      end
    end else if (wr_slot) begin
      slot[slot_of(reg_idx)] <= pwdata[7:0];                  // RQ8
    end
  end

  // sequencer walk over the slots
  // idle waits for the start bit; fetch looks at the slot under the
  // pointer for one cycle and picks play, pause or end; play waits for the
  // player's done pulse, pause for the timer's done pulse.
  // a stop write wins over every other event in the same cycle, so an
  // abort can never be lost behind a done pulse.
  // the end marker is tested before the mode bit: a pause of zero length
  // would otherwise wrap the timer to 128 units and not end the sequence.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= SEQ_IDLE;
      slot_ptr <= 3'h0;
    end else if (stop_req) begin
      // writing zero to the start bit abandons the sequence
      state    <= SEQ_IDLE;
      slot_ptr <= 3'h0;
    end else begin
      unique case (state)
        SEQ_IDLE: begin
          if (start_req) begin
            slot_ptr <= 3'h0;                                  // RQ4
            state    <= SEQ_FETCH;                             // RQ4
          end
        end
        SEQ_FETCH: begin
          if (cur_end) begin
            state <= SEQ_IDLE;                                 // RQ7
          end else if (cur_pause) begin
            state <= SEQ_PAUSE;                                // RQ1
          end else begin
            state <= SEQ_PLAY;                                 // RQ2
          end
        end
        SEQ_PLAY, SEQ_PAUSE: begin
          if (step_done) begin
            if (at_last) begin
              state    <= SEQ_IDLE;                            // RQ6
              slot_ptr <= 3'h0;
            end else begin
              slot_ptr <= slot_ptr + 3'h1;                     // RQ5
              state    <= SEQ_FETCH;                           // RQ5
            end
          end
        end
      endcase
    end
  end

  // player handshake; pulse and index leave straight from flops
  // launches are decoded from the fetch state, so each start pulse is one
  // cycle wide by construction and the index is held until the next one.
  // drive_enable follows the effect only: it drops the cycle after done
  // and stays low for the whole of a pause slot and while idle.
  wire launch_effect = (state == SEQ_FETCH) && !cur_end && !cur_pause && !stop_req;
  wire launch_pause  = (state == SEQ_FETCH) && !cur_end && cur_pause && !stop_req;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      effect_start <= 1'b0;
      effect_index <= 7'h00;
      drive_enable <= 1'b0;
    end else begin
      effect_start <= launch_effect;                           // RQ2
      if (launch_effect) begin
        effect_index <= cur_value;                             // RQ3
      end
      // drive only while an effect slot plays, never across a pause
      drive_enable <= launch_effect
                      || (drive_enable && (state == SEQ_PLAY)
                          && !effect_done && !stop_req);       // RQ9
    end
  end

  // pause time base; count is the slot value in 10 ms units
  // the timer is loaded from fetch together with the move to pause, so the
  // pause runs a cycle or two longer than the bare unit count; at the
  // 10 ms unit this slack is far below anything a user could feel.
  // the same stop write that idles the walk also stops the timer.
  pause_timer #(
    .UNIT_CYCLES (PAUSE_CYCLES)
  ) u_pause_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (launch_pause),                                   // RQ9
    .abort   (stop_req),
    .units   (cur_value),                                      // RQ1
    .done    (pause_done)
  );
endmodule : waveform_sequencer_slots

// [bench/waveform_sequencer_slots_props.sv]
/*
  port assertions for the slot sequencer.
  assumes pclk and presetn of the top module; bound to every instance.
*/
`timescale 1ns/1ps
module waveform_sequencer_slots_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        effect_done,
  input wire logic        effect_start,
  input wire logic [6:0]  effect_index,
  input wire logic        drive_enable
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_upper_reads_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  a_start_one_cycle: assert property (effect_start |=> !effect_start)
    else $error("effect start longer than a cycle");
  a_drive_with_start: assert property (effect_start |-> drive_enable)
    else $error("drive off while effect starts");
  a_drive_rise_cause: assert property ($rose(drive_enable) |-> effect_start)
    else $error("drive rose without effect start");
  a_index_held: assert property ($changed(effect_index) |-> effect_start)
    else $error("index moved without start");
  a_end_not_played: assert property (effect_start |-> effect_index != 7'h00)
    else $error("zero index played");
  a_drive_drop: assert property (drive_enable && effect_done |=> !drive_enable)
    else $error("drive held after effect done");
endmodule : waveform_sequencer_slots_props

bind waveform_sequencer_slots waveform_sequencer_slots_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .effect_done(effect_done),
  .effect_start(effect_start), .effect_index(effect_index),
  .drive_enable(drive_enable)
);

// [bench/waveform_sequencer_slots_tb.sv]
/*
  self-checking bench: apb register access and slot walks.
  assumes the sequencer built with a 10-cycle pause unit.
*/
`timescale 1ns/1ps
module waveform_sequencer_slots_tb;
  import seq_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        effect_done = 0, pready, pslverr, effect_start, drive_enable, e;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [6:0]  effect_index;
  logic [7:0]  seq [8] = '{8'h01, 8'h82, 8'h7F, 8'h03, 8'h04, 8'h55, 8'h81, 8'h06};
  int          err_count = 0, checks_done = 0;
  always #50 pclk = ~pclk;
  waveform_sequencer_slots #(.PAUSE_CYCLES(10)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .effect_done(effect_done),
    .effect_start(effect_start), .effect_index(effect_index), .drive_enable(drive_enable));
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; an idle edge first keeps strobes from being set twice
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    int n = 0;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin err_count++; stop_test(); end
    r = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask : bus
  // player stand-in: waits for a start, answers done a few cycles later
  task automatic play(input logic [6:0] idx, output int n);
    int hi = 0;
    n = 0;
    do begin
      @(posedge pclk); n++;
      if (drive_enable === 1'b1 && effect_start !== 1'b1) hi++;
    end while (effect_start !== 1'b1 && n < 400);
    if (n >= 400) begin err_count++; stop_test(); end
    chk(effect_index, idx);
    chk(drive_enable, 1);
    chk(hi, 0);
    repeat (3) @(posedge pclk);
    effect_done <= 1;
    @(posedge pclk) effect_done <= 0;
  endtask : play
  // load all slots, start, and follow the walk the slots describe
  task automatic run_seq;
    int w = 0, n, cnt = 0;
    for (int i = 0; i < 8; i++) bus(1, {IDX_SLOT_FIRST + 6'(i), 2'b00}, {24'h0, seq[i]}, q, e);
    bus(1, {IDX_CONTROL, 2'b00}, 32'h1, q, e);
    for (int i = 0; i < 8; i++) begin
      if (seq[i][6:0] == 7'h00) break;
      if (seq[i][7]) w += 10 * seq[i][6:0];
      else begin
        play(seq[i][6:0], n);
        chk(n >= w && n <= w + 10, 1);
        w = 0;
      end
    end
    repeat (60) begin @(posedge pclk); if (effect_start === 1'b1) cnt++; end
    chk(cnt, 0);
    bus(0, {IDX_CONTROL, 2'b00}, 32'h0, q, e);
    chk(q[0], 0);
  endtask : run_seq
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    for (int s = 0; s < 2; s++) begin
      bus(0, {IDX_SLOT_SIX + 6'(s), 2'b00}, 32'h0, q, e);
      chk(q, 0);
      foreach (seq[k]) begin
        bus(1, {IDX_SLOT_SIX + 6'(s), 2'b00}, {24'hFFFFFF, seq[k]}, q, e);
        bus(0, {IDX_SLOT_SIX + 6'(s), 2'b00}, 32'h0, q, e);
        chk(q, {24'h0, seq[k]});
      end
    end
    bus(0, 8'hFC, 32'h0, q, e);
    chk(e, 1);
    run_seq();
    seq[5] = 8'h00;
    run_seq();
    stop_test();
  end
endmodule : waveform_sequencer_slots_tb
